// ### src/mss_top.sv
// Modulation source sequencer: APB registers, point-clock player, sweep, FSK and burst control.
//
// Overview of operation
// - Sweep steps 2048 to 4096 phase-continuous frequencies.
// - Stop above start gives rising ramp.
// - Linear uses point index as ramp, log exponential table.
// - Carrier is mean, deviation half difference.
// - Parameter change reloads RAM; sweep time sets period.
// - Each trigger starts one modulation cycle.
// - FSK square wave zero/one, internal rate.
// - External hop pin: low carrier, high hop.
// - Hop deviation is hop minus carrier.
// - Each trigger yields programmed carrier cycle count.
// - Burst holds start-phase sample between triggers; the code parks at start phase but holds dac_enable_o low there.
// - Gate high runs carrier, low zeros output.
// - Burst signal halts addressing at last point.
// - External trigger replaces internal burst rate.
// - Burst setting change forces modulation reload.
// - Minimum burst count one per megahertz band.
// - Waveforms 2048 to 4096 points, software-resized.
// - Eight-bit AM and twelve-bit FM samples.
// - Samples read at variable point clock.
// - Prescaler is constant over frequency, at least one.
// - Length is 2C over (1+S)F, even.
`timescale 1ns/1ps
module mss_top import mss_pkg::*; #(
  parameter int DEPTH = PTS_MAX
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ext_trig_i,
  input wire logic ext_hop_i,
  input wire logic burst_gate_i,
  input wire logic carrier_wrap_i,
  output logic [7:0] am_sample_o,
  output logic [11:0] fm_sample_o,
  output logic [31:0] carrier_freq_o,
  output logic signed [31:0] deviation_o,
  output logic dac_enable_o,
  output logic addr_halt_o,
  output logic reload_req_o
);

  // ==========================================================================
  // Registers and synchronisers
  // ==========================================================================
  logic [31:0] ctrl_q, start_q, stop_q, hop_q, modf_q, burst_q, rate_q;
  logic [11:0] waddr_q;
  logic [11:0] ram_q [DEPTH];
  logic [2:0] trig_s_q;
  // Hop and gate are levels, so two stages suffice; the trigger keeps a third for its edge.
  logic [1:0] hop_s_q, gate_s_q;
  logic reload_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      trig_s_q <= 3'h0;
      hop_s_q <= 2'h0;
      gate_s_q <= 2'h0;
    end else begin
      trig_s_q <= {trig_s_q[1:0], ext_trig_i};
      hop_s_q <= {hop_s_q[0], ext_hop_i};
      gate_s_q <= {gate_s_q[0], burst_gate_i};
    end
  end

  wire ext_trig_rise = trig_s_q[1] & ~trig_s_q[2];
  wire hop_lvl = hop_s_q[1];
  wire gate_lvl = gate_s_q[1];

  // ==========================================================================
  // APB slave, zero wait states
  // ==========================================================================
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire known = (paddr_i <= MSS_PRESC) && (paddr_i[1:0] == 2'b00);
  wire bus_trig = wr && paddr_i == MSS_TRIG;
  wire mode_sel_fm = ctrl_q[CTRL_AM_BIT] == 1'b0;
  mss_mode_t mode;
  assign mode = mss_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);

  // Any parameter write asks software to recompute and reload modulation RAM.
  wire param_wr = wr && known && paddr_i != MSS_TRIG && paddr_i != MSS_WDATA
    && paddr_i != MSS_WADDR && paddr_i != MSS_STATUS && paddr_i != MSS_PRESC;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= CTRL_RST;
      start_q <= 32'h0;
      stop_q <= 32'h0;
      hop_q <= 32'h0;
      modf_q <= 32'h1;
      burst_q <= 32'h1;
      rate_q <= 32'h0;
      waddr_q <= 12'h000;
    end else if (wr) begin
      if (paddr_i == MSS_CTRL) ctrl_q <= pwdata_i;
      if (paddr_i == MSS_START) start_q <= pwdata_i;
      if (paddr_i == MSS_STOP) stop_q <= pwdata_i;
      if (paddr_i == MSS_HOP) hop_q <= pwdata_i;
      if (paddr_i == MSS_MODF) modf_q <= (pwdata_i == 32'h0) ? 32'h1 : pwdata_i;
      if (paddr_i == MSS_BURST) burst_q <= pwdata_i;
      if (paddr_i == MSS_RATE) rate_q <= pwdata_i;
      if (paddr_i == MSS_WADDR) waddr_q <= pwdata_i[11:0];
      if (paddr_i == MSS_WDATA) waddr_q <= waddr_q + 12'h001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr && paddr_i == MSS_WDATA) ram_q[waddr_q] <= pwdata_i[11:0];
  end

  // ==========================================================================
  // Prescaler, length and derived values
  // ==========================================================================
  wire [31:0] kconst = mode_sel_fm ? 32'(K_FM) : 32'(K_AM);
  wire [31:0] presc_raw = kconst / modf_q;
  wire [31:0] presc = (presc_raw == 32'h0) ? 32'h1 : presc_raw;
  wire [31:0] pclk_max = mode_sel_fm ? 32'(PCLK_FM_HZ) : 32'(PCLK_AM_HZ);
  wire [63:0] len_den = 64'(presc + 32'h1) * 64'(modf_q);
  wire [63:0] len_raw = (64'(pclk_max) << 1) / len_den;
  wire [63:0] len_clip = (len_raw > 64'(PTS_MAX)) ? 64'(PTS_MAX)
    : (len_raw < 64'(PTS_MIN)) ? 64'(PTS_MIN) : len_raw;
  wire [12:0] pts = {len_clip[12:1], 1'b0};
  // Sample rate = max point clock / S; counted in system clocks.
  wire [31:0] base_div = mode_sel_fm ? 32'(DIV_FM) : 32'(DIV_AM);
  wire [31:0] tick_div = base_div * presc;

  wire sweep_up = stop_q >= start_q;
  wire [32:0] sum_ss = 33'(start_q) + 33'(stop_q);
  wire signed [32:0] diff_ss = $signed({1'b0, start_q}) - $signed({1'b0, stop_q});
  wire signed [32:0] hop_dev = $signed({1'b0, hop_q}) - $signed({1'b0, start_q});

  // Minimum burst count grows one per MHz band up to five.
  function automatic logic [31:0] min_burst(input logic [31:0] f);
    logic [31:0] b;
    b = (f + 32'(MHZ) - 32'h1) / 32'(MHZ);
    if (b == 32'h0) b = 32'h1;
    if (b > 32'(MAX_BURST_MIN)) b = 32'(MAX_BURST_MIN);
    return b;
  endfunction
  wire [31:0] burst_min = min_burst(start_q);
  wire [31:0] burst_eff = (burst_q < burst_min) ? burst_min : burst_q;

  // ==========================================================================
  // Point player and burst sequencer
  // ==========================================================================
  mss_state_t st_q;
  logic [31:0] tick_q, rate_cnt_q, cyc_q;
  logic [12:0] idx_q;
  logic fsk_q;

  wire tick = tick_q >= tick_div - 32'h1;
  wire int_rate = rate_q != 32'h0 && rate_cnt_q >= rate_q - 32'h1;
  wire trig_src = ctrl_q[CTRL_EXTSRC_BIT] ? ext_trig_rise : int_rate;
  wire trig_any = trig_src | bus_trig;
  wire triggered = ctrl_q[CTRL_TRIG_BIT] || mode == MSS_BURST_TRIG;
  wire last_pt = idx_q == pts - 13'h1;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tick_q <= 32'h0;
      rate_cnt_q <= 32'h0;
    end else begin
      tick_q <= tick ? 32'h0 : tick_q + 32'h1;
      rate_cnt_q <= int_rate ? 32'h0 : rate_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_q <= ST_IDLE;
      idx_q <= 13'h0;
      cyc_q <= 32'h0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          idx_q <= 13'h0;
          st_q <= triggered ? ST_HOLD : ST_RUN;
        end
        ST_RUN: begin
          if (mode == MSS_BURST_TRIG) begin
            if (carrier_wrap_i) begin
              if (cyc_q + 32'h1 >= burst_eff) begin
                cyc_q <= 32'h0;
                st_q <= ST_HOLD;
              end else begin
                cyc_q <= cyc_q + 32'h1;
              end
            end
          end else if (tick) begin
            idx_q <= last_pt ? 13'h0 : idx_q + 13'h1;
            if (last_pt && triggered) st_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          idx_q <= 13'h0;
          if (trig_any) st_q <= ST_RUN;
          if (!triggered) st_q <= ST_RUN;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Internal FSK rate flips the square wave every rate period.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) fsk_q <= 1'b0;
    else if (int_rate) fsk_q <= ~fsk_q;
  end
  wire fsk_lvl = ctrl_q[CTRL_EXTSRC_BIT] ? hop_lvl : fsk_q;

  // ==========================================================================
  // Output stage
  // ==========================================================================
  wire [11:0] ram_rd = ram_q[idx_q[11:0]];
  // Log sweeps use the exponential table software loaded; sign follows direction.
  wire [11:0] sweep_s = ctrl_q[CTRL_LOG_BIT] ? ram_rd : idx_q[11:0];
  wire [11:0] sweep_v = sweep_up ? sweep_s : ~sweep_s;
  wire [11:0] fm_d = (mode == MSS_SWEEP) ? sweep_v
    : (mode == MSS_FSK) ? {12{fsk_lvl}} : ram_rd;
  wire gate_d = (mode == MSS_BURST_GATE) ? gate_lvl
    : (mode == MSS_BURST_TRIG) ? (st_q == ST_RUN) : 1'b1;
  wire [31:0] car_d = (mode == MSS_SWEEP) ? sum_ss[32:1]
    : (mode == MSS_FSK) ? start_q : (sum_ss[32:1]);
  wire signed [31:0] dev_d = (mode == MSS_FSK) ? hop_dev[31:0]
    : 32'(diff_ss >>> 1);

  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0;
    unique case (paddr_i)
      MSS_CTRL: rd_d = ctrl_q;
      MSS_START: rd_d = start_q;
      MSS_STOP: rd_d = stop_q;
      MSS_HOP: rd_d = hop_q;
      MSS_MODF: rd_d = modf_q;
      MSS_BURST: rd_d = burst_eff;
      MSS_RATE: rd_d = rate_q;
      MSS_STATUS: rd_d = {16'h0, 3'h0, pts};
      MSS_WADDR: rd_d = {20'h0, waddr_q};
      MSS_PRESC: rd_d = presc;
      default: rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      am_sample_o <= 8'h00;
      fm_sample_o <= 12'h000;
      carrier_freq_o <= 32'h0;
      deviation_o <= 32'sh0;
      dac_enable_o <= 1'b0;
      addr_halt_o <= 1'b0;
      reload_q <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~known;
      prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rd_d : 32'h0;
      fm_sample_o <= fm_d;
      am_sample_o <= fm_d[11:4];
      carrier_freq_o <= car_d;
      deviation_o <= dev_d;
      dac_enable_o <= gate_d;
      addr_halt_o <= (mode == MSS_BURST_TRIG) && st_q != ST_RUN;
      reload_q <= param_wr;
    end
  end
  assign reload_req_o = reload_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_gate;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      mode == MSS_BURST_GATE && gate_s_q[1] == 1'b0 |=> !dac_enable_o;
  endproperty
  a_gate: assert property (p_gate) else $error("gate low did not zero dac");

  property p_presc;
    @(posedge ref_clk_i) disable iff (sys_rst_i) presc >= 32'h1;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler below one");

  property p_pts;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      pts >= 13'(PTS_MIN) && pts <= 13'(PTS_MAX) && pts[0] == 1'b0;
  endproperty
  a_pts: assert property (p_pts) else $error("length out of range");

  property p_reload;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      wr && paddr_i == MSS_BURST |=> reload_req_o;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload after change");

  property p_bmin;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      burst_eff >= 32'h1 && burst_eff >= burst_min;
  endproperty
  a_bmin: assert property (p_bmin) else $error("burst count below minimum");

  property p_fsk;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      mode == MSS_FSK && $stable(mode) && ctrl_q[CTRL_EXTSRC_BIT] && hop_s_q[1]
      |=> fm_sample_o == 12'hFFF;
  endproperty
  a_fsk: assert property (p_fsk) else $error("hop high not hop");

  property p_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      st_q == ST_HOLD |=> idx_q == 13'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not at start phase");

  property p_halt;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      mode == MSS_BURST_TRIG && $stable(mode) && st_q == ST_HOLD |=> addr_halt_o;
  endproperty
  a_halt: assert property (p_halt) else $error("addressing not halted");

  property p_trig;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      st_q == ST_HOLD && triggered && trig_any |=> st_q == ST_RUN;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not start a cycle");

  // A burst must neither stop early nor run past its count of carrier cycles.
  property p_count;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      mode == MSS_BURST_TRIG && st_q == ST_RUN && carrier_wrap_i
      && cyc_q + 32'h1 < burst_eff |=> st_q == ST_RUN;
  endproperty
  a_count: assert property (p_count) else $error("burst ended before its count");

  property p_count_end;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      mode == MSS_BURST_TRIG && st_q == ST_RUN && carrier_wrap_i
      && cyc_q + 32'h1 >= burst_eff |=> st_q == ST_HOLD;
  endproperty
  a_count_end: assert property (p_count_end) else $error("burst ran past its count");

  property p_gate_hi;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      mode == MSS_BURST_GATE && gate_lvl |=> dac_enable_o;
  endproperty
  a_gate_hi: assert property (p_gate_hi) else $error("gate high did not run dac");

  property p_hop_lo;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      mode == MSS_FSK && ctrl_q[CTRL_EXTSRC_BIT] && !hop_lvl |=> fm_sample_o == 12'h000;
  endproperty
  a_hop_lo: assert property (p_hop_lo) else $error("hop low not carrier");

  // With the external source chosen, the internal rate must never start a burst.
  property p_ext_only;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      st_q == ST_HOLD && triggered && ctrl_q[CTRL_EXTSRC_BIT] && !ext_trig_rise && !bus_trig
      |=> st_q == ST_HOLD;
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("internal rate started a burst");

  c_trig: cover property (@(posedge ref_clk_i) st_q == ST_HOLD ##1 st_q == ST_RUN);
  c_gate: cover property (@(posedge ref_clk_i) mode == MSS_BURST_GATE && !dac_enable_o);
  c_reload: cover property (@(posedge ref_clk_i) reload_req_o);
  c_hop: cover property (@(posedge ref_clk_i) mode == MSS_FSK && fm_sample_o == 12'hFFF);
  c_burst_end: cover property (@(posedge ref_clk_i) st_q == ST_RUN ##1 st_q == ST_HOLD);

endmodule

// ### src/mss_pkg.sv
// Package for the modulation source sequencer: register map, fields, timing and types.
package mss_pkg;

  // ==========================================================================
  // Register map (byte addresses on APB)
  // ==========================================================================
  localparam logic [7:0] MSS_CTRL = 8'h00;
  localparam logic [7:0] MSS_START = 8'h04;
  localparam logic [7:0] MSS_STOP = 8'h08;
  localparam logic [7:0] MSS_HOP = 8'h0C;
  localparam logic [7:0] MSS_MODF = 8'h10;
  localparam logic [7:0] MSS_BURST = 8'h14;
  localparam logic [7:0] MSS_RATE = 8'h18;
  localparam logic [7:0] MSS_TRIG = 8'h1C;
  localparam logic [7:0] MSS_STATUS = 8'h20;
  localparam logic [7:0] MSS_WADDR = 8'h24;
  localparam logic [7:0] MSS_WDATA = 8'h28;
  localparam logic [7:0] MSS_PRESC = 8'h2C;

  // ==========================================================================
  // Control field positions
  // ==========================================================================
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LOG_BIT = 3;
  localparam int CTRL_TRIG_BIT = 4;
  localparam int CTRL_EXTSRC_BIT = 5;
  localparam int CTRL_AM_BIT = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ==========================================================================
  // Waveform and timing constants
  // ==========================================================================
  localparam int PTS_MIN = 2048;
  localparam int PTS_MAX = 4096;
  localparam int K_FM = 624;
  localparam int K_AM = 4900;
  localparam int CLK_HZ = 25_000_000;
  localparam int PCLK_FM_HZ = 1_250_000;
  localparam int PCLK_AM_HZ = 5_000_000;
  localparam int DIV_FM = CLK_HZ / PCLK_FM_HZ;
  localparam int DIV_AM = CLK_HZ / PCLK_AM_HZ;
  localparam int MHZ = 1_000_000;
  localparam int MAX_BURST_MIN = 5;

  typedef enum logic [2:0] {
    MSS_OFF = 3'b000,
    MSS_SWEEP = 3'b001,
    MSS_FSK = 3'b010,
    MSS_BURST_TRIG = 3'b011,
    MSS_BURST_GATE = 3'b100,
    MSS_FM = 3'b101
  } mss_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } mss_state_t;

  typedef struct packed {
    logic [11:0] fm;
    logic [7:0] am;
    logic gate;
    logic hold;
  } mss_out_t;

endpackage

// ### test/mss_carrier_model.sv
// Behavioural model of the carrier synthesizer that paces the sequencer with end-of-cycle pulses.
`timescale 1ns/1ps
module mss_carrier_model #(
  parameter int PERIOD = 10
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic halt_i,
  output logic wrap_o
);
  // ==========================================================================
  // Carrier address counter
  // ==========================================================================
  // A halted memory address parks at the first point, so a burst always restarts at zero phase.
  logic [7:0] cnt_q;
  logic last;
  assign last = (cnt_q == 8'(PERIOD - 1));
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || halt_i) begin
      cnt_q <= 8'h00;
      wrap_o <= 1'b0;
    end else begin
      wrap_o <= last;
      cnt_q <= last ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule

// ### test/modulation_source_sequencer_bench.sv
// Self-checking testbench for the modulation source sequencer.
`timescale 1ns/1ps
module modulation_source_sequencer_bench import mss_pkg::*;;
  typedef struct packed {
    logic [31:0] ctrl, start, stop, hop, modf, car, dev, presc, pts;
  } mss_row_t;
  logic ref_clk_i, sys_rst_i, psel, penable, pwrite, ext_trig, ext_hop, gate, wrap;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_o, carrier_freq_o, rd;
  logic signed [31:0] deviation_o;
  logic pready_o, pslverr_o, dac_enable_o, addr_halt_o, reload_req_o, err;
  logic [7:0] am_sample_o;
  logic [11:0] fm_sample_o, fm_a;
  int n_fail, checks_done, cyc, n_reload, n_wrap, r0;
  mss_row_t rows [5];
  int bstart [4];
  int bexp [4];

  mss_top dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_trig_i(ext_trig), .ext_hop_i(ext_hop),
    .burst_gate_i(gate), .carrier_wrap_i(wrap), .am_sample_o(am_sample_o),
    .fm_sample_o(fm_sample_o), .carrier_freq_o(carrier_freq_o), .deviation_o(deviation_o),
    .dac_enable_o(dac_enable_o), .addr_halt_o(addr_halt_o), .reload_req_o(reload_req_o));
  mss_carrier_model #(.PERIOD(10)) carrier (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .halt_i(addr_halt_o), .wrap_o(wrap));

  // ==========================================================================
  // Clock, timeout and monitors
  // ==========================================================================
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (reload_req_o === 1'b1) n_reload++;
    if (wrap === 1'b1 && addr_halt_o === 1'b0) n_wrap++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The request is held until pready is sampled high; the bench timeout ends a hang.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic burst_run(input logic use_bus);
    r0 = n_wrap;
    if (use_bus) apb(1'b1, MSS_TRIG, 32'h0000_0001);
    else begin
      @(posedge ref_clk_i) ext_trig <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      ext_trig <= 1'b0;
    end
    repeat (300) @(posedge ref_clk_i);
    check(32'(n_wrap - r0), 32'h0000_0003);
    check(32'(addr_halt_o), 32'h0000_0001);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {psel, penable, pwrite, ext_trig, ext_hop, gate} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sys_rst_i = 1'b1;
    rows[0] = '{32'h01, 1000, 3000, 0, 100, 2000, -1000, 6, 3570};
    rows[1] = '{32'h09, 5000, 1000, 0, 50, 3000, 2000, 12, 3846};
    rows[2] = '{32'h02, 3000, 0, 500, 1000, 3000, -2500, 1, 0};
    rows[3] = '{32'h02, 1000, 0, 4000, 200, 1000, 3000, 3, 0};
    rows[4] = '{32'h45, 2000, 2000, 0, 100, 2000, 0, 49, 0};
    bstart = '{500_000, 1_500_000, 3_500_000, 5_000_000};
    bexp = '{1, 2, 4, 5};
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    apb(1'b0, MSS_CTRL, 32'h0);
    check(rd, CTRL_RST);
    apb(1'b0, 8'h30, 32'h0);
    check({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, 8'h05, 32'hFFFF_FFFF);
    check(32'(err), 32'h0000_0001);
    foreach (rows[i]) begin
      apb(1'b1, MSS_CTRL, rows[i].ctrl);
      apb(1'b1, MSS_STOP, rows[i].stop);
      apb(1'b1, MSS_HOP, rows[i].hop);
      apb(1'b1, MSS_MODF, rows[i].modf);
      // Let the pulse of the frequency write reach the counter before the baseline is taken.
      repeat (2) @(posedge ref_clk_i);
      r0 = n_reload;
      apb(1'b1, MSS_START, rows[i].start);
      repeat (4) @(posedge ref_clk_i);
      check(32'(n_reload - r0), 32'h0000_0001);
      check(carrier_freq_o, rows[i].car);
      check(deviation_o, rows[i].dev);
      apb(1'b0, MSS_PRESC, 32'h0);
      check(rd, rows[i].presc);
      if (rows[i].pts != 0) begin
        apb(1'b0, MSS_STATUS, 32'h0);
        check(rd, rows[i].pts);
      end
    end
    foreach (bstart[i]) begin
      apb(1'b1, MSS_START, bstart[i]);
      apb(1'b1, MSS_BURST, 32'h0000_0001);
      apb(1'b0, MSS_BURST, 32'h0);
      check(rd, bexp[i]);
    end
    apb(1'b1, MSS_START, 500_000);
    apb(1'b1, MSS_BURST, 32'h0000_0003);
    apb(1'b1, MSS_CTRL, 32'h0000_0033);
    // The burst already running must finish its three carrier cycles before it parks.
    repeat (40) @(posedge ref_clk_i);
    check(32'(addr_halt_o), 32'h0000_0001);
    burst_run(1'b0);
    burst_run(1'b1);
    apb(1'b1, MSS_CTRL, 32'h0000_0004);
    repeat (6) @(posedge ref_clk_i);
    check(32'(dac_enable_o), 32'h0000_0000);
    gate <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    check(32'(dac_enable_o), 32'h0000_0001);
    apb(1'b1, MSS_CTRL, 32'h0000_0022);
    repeat (6) @(posedge ref_clk_i);
    check(32'(fm_sample_o), 32'h0000_0000);
    ext_hop <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    check(32'(fm_sample_o), 32'h0000_0FFF);
    check(32'(am_sample_o), 32'h0000_00FF);
    apb(1'b1, MSS_RATE, 32'h0000_000A);
    apb(1'b1, MSS_CTRL, 32'h0000_0002);
    repeat (3) @(posedge ref_clk_i);
    fm_a = fm_sample_o;
    repeat (10) @(posedge ref_clk_i);
    check(32'(fm_sample_o ^ fm_a), 32'h0000_0FFF);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    check(carrier_freq_o, 32'h0000_0000);
    apb(1'b0, MSS_CTRL, 32'h0);
    check(rd, CTRL_RST);
    apb(1'b1, MSS_WADDR, 32'h0000_0010);
    apb(1'b1, MSS_WDATA, 32'h0000_05A5);
    apb(1'b0, MSS_WADDR, 32'h0);
    check(rd, 32'h0000_0011);
    end_of_test();
  end
endmodule
